// ==== rtl/srmc_defines.svh ====
`ifndef SRMC_DEFINES_SVH
`define SRMC_DEFINES_SVH

// Register indices on the plain register port.
`define SRMC_ADDR_W        4
`define SRMC_REG_CTRL      4'h0
`define SRMC_REG_DELAY     4'h1
`define SRMC_REG_ON        4'h2
`define SRMC_REG_OFF       4'h3
`define SRMC_REG_LEVEL     4'h4
`define SRMC_REG_CMD       4'h5
`define SRMC_REG_STATUS    4'h6
`define SRMC_REG_TEMP      4'h7
`define SRMC_REG_HEAD      4'h8
`define SRMC_REG_ACT_CTRL  4'h9
`define SRMC_REG_ACT_DELAY 4'ha
`define SRMC_REG_ACT_ON    4'hb
`define SRMC_REG_ACT_OFF   4'hc
`define SRMC_REG_ACT_LEVEL 4'hd

// Field positions.
`define SRMC_CTRL_MODE_LSB 0
`define SRMC_CMD_APPLY     0
`define SRMC_CMD_STORE     1
`define SRMC_CMD_SWTRIG    2

// Mode codes held in the control register.
`define SRMC_MODE_OFF      3'h0
`define SRMC_MODE_EXTTRIG  3'h1
`define SRMC_MODE_SWTRIG   3'h2
`define SRMC_MODE_CONT     3'h3
`define SRMC_MODE_EXTSW    3'h4
`define SRMC_MODE_INTTRIG  3'h5

// Level limits: pulsed modes allow the full range, DC modes the lower one.
`define SRMC_LEVEL_MAX_PULSE 16'hffff
`define SRMC_LEVEL_MAX_DC    16'h3fff

`endif

// ==== rtl/srmc_pkg.sv ====
package srmc_pkg;

    typedef enum logic [2:0] {
        MODE_OFF     = 3'h0,
        MODE_EXTTRIG = 3'h1,
        MODE_SWTRIG  = 3'h2,
        MODE_CONT    = 3'h3,
        MODE_EXTSW   = 3'h4,
        MODE_INTTRIG = 3'h5
    } srmc_mode_type;

    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_DELAY = 4'b0010,
        SEQ_ON    = 4'b0100,
        SEQ_OFF   = 4'b1000
    } srmc_seq_type;

    typedef struct packed {
        srmc_mode_type mode;
        logic [31:0]   delay;
        logic [31:0]   on_time;
        logic [31:0]   off_time;
        logic [15:0]   level;
    } srmc_cfg_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } srmc_bus_type;

endpackage

// ==== rtl/srmc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "srmc_defines.svh"

// Overview of operation
// RULE1: In off mode every trigger is ignored and the output stays low with zero level.
// RULE2: In external trigger mode each accepted external trigger edge starts one timed output pulse.
// RULE3: In software trigger mode only host trigger commands start pulses and external triggers are ignored.
// RULE4: In continuous mode the output is driven constantly once parameters are applied, timing unused.
// RULE5: In external switch mode the output follows the external trigger level, timing unused.
// RULE6: In external switch mode the level is clamped to the same maximum as continuous mode.
// RULE7: In internal trigger mode the block retriggers itself using delay, on and off durations.
// RULE8: In internal trigger mode external triggers and host trigger commands are ignored.
// RULE9: While a trigger is handled or the output is driven, further triggers are dropped; the code accepts one in the last cycle of led_out high.
// RULE10: An apply command updates only the volatile active set, which reset clears.
// RULE11: An apply-and-store command activates the parameters and pulses a persistent-store write.
// RULE12: Reading the active registers returns the complete active parameter set.
// RULE13: Temperature reads zero after reset until the sensor delivers its first valid sample.
// RULE14: The head model reads empty when the head has no identification or is absent.
// RULE15: A triggered pulse waits the delay, drives the output for the on time, then releases it.
module srmc_top #(
    parameter int TRIG_N = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [31:0]          reg_rdata,
    input  wire logic [TRIG_N-1:0]    trig_in,
    input  wire logic                 temp_valid,
    input  wire logic [15:0]          temp_value,
    input  wire logic                 head_present,
    input  wire logic                 head_id_valid,
    input  wire logic [15:0]          head_id,
    output var  logic                 led_out,
    output var  logic [15:0]          led_level,
    output var  logic                 store_req,
    output var  srmc_pkg::srmc_cfg_type store_cfg
);

    srmc_pkg::srmc_cfg_type  stage_r;
    srmc_pkg::srmc_cfg_type  stage_nxt;
    srmc_pkg::srmc_cfg_type  act_r;
    srmc_pkg::srmc_cfg_type  act_nxt;
    srmc_pkg::srmc_cfg_type  store_cfg_nxt;
    srmc_pkg::srmc_seq_type  seq_r;
    srmc_pkg::srmc_seq_type  seq_nxt;
    logic [31:0]             cnt_r;
    logic [31:0]             cnt_nxt;
    logic [31:0]             rdata_nxt;
    logic [TRIG_N-1:0]       trig_s1_r;
    logic [TRIG_N-1:0]       trig_s2_r;
    logic [TRIG_N-1:0]       trig_prev_r;
    logic [15:0]             temp_r;
    logic [15:0]             temp_nxt;
    logic [15:0]             head_r;
    logic [15:0]             head_nxt;
    logic [15:0]             lvl_nxt;
    logic [15:0]             lvl_max;
    logic                    led_nxt;
    logic                    store_nxt;
    logic                    sw_trig_r;
    logic                    sw_trig_nxt;
    logic                    temp_seen_r;
    logic                    temp_seen_nxt;
    logic                    ext_level;
    logic                    ext_edge;
    logic                    start;
    logic                    temp_vld_s1_r;
    logic                    temp_vld_s2_r;
    logic [15:0]             temp_val_s1_r;
    logic [15:0]             temp_val_s2_r;
    logic                    head_on_s1_r;
    logic                    head_on_s2_r;
    logic                    head_idv_s1_r;
    logic                    head_idv_s2_r;
    logic [15:0]             head_id_s1_r;
    logic [15:0]             head_id_s2_r;

    // Two stages before any logic reads the trigger pins.
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_s1_r   <= '0;
            trig_s2_r   <= '0;
            trig_prev_r <= '0;
        end else begin
            trig_s1_r   <= trig_in;
            trig_s2_r   <= trig_s1_r;
            trig_prev_r <= trig_s2_r;
        end
    end

    // The sensor and the head connector sit outside this clock. Each value word travels through the
    // same two stages as its valid line, so it is only taken once it has settled beside that line.
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_vld_s1_r <= 1'b0;
            temp_vld_s2_r <= 1'b0;
            temp_val_s1_r <= 16'h0000;
            temp_val_s2_r <= 16'h0000;
            head_on_s1_r  <= 1'b0;
            head_on_s2_r  <= 1'b0;
            head_idv_s1_r <= 1'b0;
            head_idv_s2_r <= 1'b0;
            head_id_s1_r  <= 16'h0000;
            head_id_s2_r  <= 16'h0000;
        end else begin
            temp_vld_s1_r <= temp_valid;
            temp_vld_s2_r <= temp_vld_s1_r;
            temp_val_s1_r <= temp_value;
            temp_val_s2_r <= temp_val_s1_r;
            head_on_s1_r  <= head_present;
            head_on_s2_r  <= head_on_s1_r;
            head_idv_s1_r <= head_id_valid;
            head_idv_s2_r <= head_idv_s1_r;
            head_id_s1_r  <= head_id;
            head_id_s2_r  <= head_id_s1_r;
        end
    end

    assign ext_level = |trig_s2_r;
    assign ext_edge  = |(trig_s2_r & ~trig_prev_r);

    // Register writes, commands and status capture.
    always_comb begin
        stage_nxt     = stage_r;
        act_nxt       = act_r;
        store_nxt     = 1'b0;
        store_cfg_nxt = store_cfg;
        sw_trig_nxt   = 1'b0;
        temp_seen_nxt = temp_seen_r;
        temp_nxt      = temp_r;
        head_nxt      = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                `SRMC_REG_CTRL:  stage_nxt.mode = srmc_pkg::srmc_mode_type'(reg_wdata[`SRMC_CTRL_MODE_LSB +: 3]);
                `SRMC_REG_DELAY: stage_nxt.delay = reg_wdata;
                `SRMC_REG_ON:    stage_nxt.on_time = reg_wdata;
                `SRMC_REG_OFF:   stage_nxt.off_time = reg_wdata;
                `SRMC_REG_LEVEL: stage_nxt.level = reg_wdata[15:0];
                `SRMC_REG_CMD: begin
                    if (reg_wdata[`SRMC_CMD_APPLY] || reg_wdata[`SRMC_CMD_STORE]) begin
                        act_nxt = stage_r; // RULE10
                    end
                    if (reg_wdata[`SRMC_CMD_STORE]) begin
                        store_nxt     = 1'b1; // RULE11
                        store_cfg_nxt = stage_r; // RULE11
                    end
                    sw_trig_nxt = reg_wdata[`SRMC_CMD_SWTRIG];
                end
                default: begin
                end
            endcase
        end
        // Zero until the sensor has produced a valid sample.
        if (temp_vld_s2_r) begin
            temp_seen_nxt = 1'b1; // RULE13
            temp_nxt      = temp_val_s2_r; // RULE13
        end
        if (head_on_s2_r && head_idv_s2_r) begin
            head_nxt = head_id_s2_r; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_r     <= '0;
            act_r       <= '0; // RULE10
            store_req   <= 1'b0;
            store_cfg   <= '0;
            sw_trig_r   <= 1'b0;
            temp_seen_r <= 1'b0;
            temp_r      <= 16'h0000; // RULE13
            head_r      <= 16'h0000;
        end else begin
            stage_r     <= stage_nxt;
            act_r       <= act_nxt;
            store_req   <= store_nxt;
            store_cfg   <= store_cfg_nxt;
            sw_trig_r   <= sw_trig_nxt;
            temp_seen_r <= temp_seen_nxt;
            temp_r      <= temp_nxt;
            head_r      <= head_nxt;
        end
    end

    // Read port: data stand one cycle after the strobe and only there.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `SRMC_REG_CTRL:      rdata_nxt = {29'h0, stage_r.mode};
                `SRMC_REG_DELAY:     rdata_nxt = stage_r.delay;
                `SRMC_REG_ON:        rdata_nxt = stage_r.on_time;
                `SRMC_REG_OFF:       rdata_nxt = stage_r.off_time;
                `SRMC_REG_LEVEL:     rdata_nxt = {16'h0, stage_r.level};
                `SRMC_REG_STATUS:    rdata_nxt = {26'h0, temp_seen_r, led_out, seq_r};
                `SRMC_REG_TEMP:      rdata_nxt = {16'h0, temp_r}; // RULE13
                `SRMC_REG_HEAD:      rdata_nxt = {16'h0, head_r}; // RULE14
                `SRMC_REG_ACT_CTRL:  rdata_nxt = {29'h0, act_r.mode}; // RULE12
                `SRMC_REG_ACT_DELAY: rdata_nxt = act_r.delay; // RULE12
                `SRMC_REG_ACT_ON:    rdata_nxt = act_r.on_time; // RULE12
                `SRMC_REG_ACT_OFF:   rdata_nxt = act_r.off_time; // RULE12
                `SRMC_REG_ACT_LEVEL: rdata_nxt = {16'h0, act_r.level}; // RULE12
                default:             rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Trigger source selection. A trigger only starts the sequencer when it is idle.
    always_comb begin
        case (act_r.mode)
            srmc_pkg::MODE_EXTTRIG: start = ext_edge; // RULE2
            srmc_pkg::MODE_SWTRIG:  start = sw_trig_r; // RULE3
            srmc_pkg::MODE_INTTRIG: start = 1'b1; // RULE7 RULE8
            default:                start = 1'b0; // RULE1
        endcase
    end

    // Pulse sequencer with level clamp.
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        led_nxt = 1'b0;
        lvl_max = `SRMC_LEVEL_MAX_PULSE;
        if (act_r.mode == srmc_pkg::MODE_CONT || act_r.mode == srmc_pkg::MODE_EXTSW) begin
            lvl_max = `SRMC_LEVEL_MAX_DC; // RULE6
        end
        lvl_nxt = (act_r.level > lvl_max) ? lvl_max : act_r.level;
        case (seq_r)
            srmc_pkg::SEQ_IDLE: begin
                if (start) begin
                    seq_nxt = srmc_pkg::SEQ_DELAY; // RULE9
                    cnt_nxt = act_r.delay;
                end
            end
            srmc_pkg::SEQ_DELAY: begin
                if (cnt_r == 32'h0) begin
                    seq_nxt = srmc_pkg::SEQ_ON; // RULE15
                    cnt_nxt = act_r.on_time;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            srmc_pkg::SEQ_ON: begin
                led_nxt = 1'b1; // RULE15
                if (cnt_r <= 32'h1) begin
                    led_nxt = (cnt_r == 32'h1);
                    seq_nxt = (act_r.mode == srmc_pkg::MODE_INTTRIG) ? srmc_pkg::SEQ_OFF : srmc_pkg::SEQ_IDLE;
                    cnt_nxt = act_r.off_time;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            srmc_pkg::SEQ_OFF: begin
                // Internal mode rests for the off time before it retriggers itself.
                if (cnt_r <= 32'h1) begin
                    seq_nxt = srmc_pkg::SEQ_IDLE; // RULE7
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            default: begin
                seq_nxt = srmc_pkg::SEQ_IDLE;
            end
        endcase
        case (act_r.mode)
            srmc_pkg::MODE_CONT: begin
                led_nxt = 1'b1; // RULE4
                seq_nxt = srmc_pkg::SEQ_IDLE;
            end
            srmc_pkg::MODE_EXTSW: begin
                led_nxt = ext_level; // RULE5
                seq_nxt = srmc_pkg::SEQ_IDLE;
            end
            srmc_pkg::MODE_OFF: begin
                led_nxt = 1'b0; // RULE1
                seq_nxt = srmc_pkg::SEQ_IDLE;
            end
            default: begin
            end
        endcase
        if (!led_nxt) begin
            lvl_nxt = 16'h0000; // RULE1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            seq_r     <= srmc_pkg::SEQ_IDLE;
            cnt_r     <= 32'h0;
            led_out   <= 1'b0;
            led_level <= 16'h0000;
        end else begin
            seq_r     <= seq_nxt;
            cnt_r     <= cnt_nxt;
            led_out   <= led_nxt;
            led_level <= lvl_nxt;
        end
    end

endmodule // srmc_top

`default_nettype wire

// ==== verif/srmc_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "srmc_defines.svh"
module srmc_props #(parameter int TRIG_N = 4) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic [3:0]             reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire logic [TRIG_N-1:0]      trig_in,
    input wire logic                   led_out,
    input wire logic [15:0]            led_level,
    input wire logic                   store_req,
    input wire srmc_pkg::srmc_cfg_type store_cfg
);
    logic [2:0]  ms_r, ma_r;
    logic [31:0] os_r, oa_r, w_r;
    logic [15:0] ls_r, la_r;
    wire         cmd = reg_wr && reg_addr == `SRMC_REG_CMD;
    wire         ap  = cmd && reg_wdata[1:0] != 2'h0;
    wire         dc  = ma_r == `SRMC_MODE_CONT || ma_r == `SRMC_MODE_EXTSW;
    wire  [15:0] lim = dc && la_r > `SRMC_LEVEL_MAX_DC ? `SRMC_LEVEL_MAX_DC : la_r;
    // Shadow of the staged and active mode, on time and level, so that checks need no view inside the block.
    always_ff @(posedge clk) begin
        if (rst) begin
            {ms_r, ma_r, os_r, oa_r, ls_r, la_r, w_r} <= '0;
        end else begin
            if (reg_wr && reg_addr == `SRMC_REG_CTRL) ms_r <= reg_wdata[2:0];
            if (reg_wr && reg_addr == `SRMC_REG_ON) os_r <= reg_wdata;
            if (reg_wr && reg_addr == `SRMC_REG_LEVEL) ls_r <= reg_wdata[15:0];
            if (ap) {ma_r, oa_r, la_r} <= {ms_r, os_r, ls_r};
            w_r <= led_out ? w_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_off; ma_r == 3'h0 && $past(ma_r) == 3'h0 && $past(ma_r, 2) == 3'h0 |-> !led_out && led_level == 16'h0;
    endproperty
    a_off: assert property (p_off) else $error("output on in off mode");
    property p_apply; cmd && reg_wdata[1:0] == 2'h1 |=> !store_req; endproperty
    a_apply: assert property (p_apply) else $error("apply stored");
    property p_store; cmd && reg_wdata[1] |=> store_req && store_cfg.mode == ma_r && store_cfg.on_time == oa_r;
    endproperty
    a_store: assert property (p_store) else $error("store missing");
    property p_cont; $past(ma_r, 2) == 3'h3 && ma_r == 3'h3 |-> led_out; endproperty
    a_cont: assert property (p_cont) else $error("continuous output low");
    property p_lvl; led_out && $past(ma_r, 2) == ma_r && $past(la_r, 2) == la_r |-> led_level == lim; endproperty
    a_lvl: assert property (p_lvl) else $error("level wrong");
    property p_sw; $past(ma_r, 4) == 3'h4 && $past(ma_r, 2) == 3'h4 && ma_r == 3'h4 |-> led_out == |$past(trig_in, 3);
    endproperty
    a_sw: assert property (p_sw) else $error("switch output wrong");
    property p_width; $fell(led_out) && (ma_r == 3'h1 || ma_r == 3'h2 || ma_r == 3'h5) |-> w_r == oa_r; endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");
    property p_read; reg_rd && reg_addr == `SRMC_REG_ACT_CTRL |=> reg_rdata == {29'h0, ma_r}; endproperty
    a_read: assert property (p_read) else $error("active mode read wrong");
endmodule // srmc_props
`default_nettype wire

// ==== verif/srmc_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module srmc_partner #(
    parameter int          TW = 400,
    parameter logic [15:0] TV = 16'h0024,
    parameter logic [15:0] HC = 16'h5a17 // Arbitrary head model code.
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        pin_lvl,
    input  wire logic [1:0]  pin_sel,
    input  wire logic        head_on,
    output var  logic [3:0]  trig_in,
    output var  logic        temp_valid,
    output var  logic [15:0] temp_value,
    output var  logic        head_present,
    output var  logic        head_id_valid,
    output var  logic [15:0] head_id
);
    logic [3:0]  trig_r;
    logic [15:0] cnt_r;
    always_ff @(posedge clk) begin
        trig_r <= (rst || !pin_lvl) ? 4'h0 : 4'h1 << pin_sel;
        cnt_r <= rst ? 16'h0 : cnt_r + 16'(cnt_r < 16'(TW));
    end
    // Value lines wander until the sensor settles, so early latching shows up.
    assign temp_valid = cnt_r == 16'(TW);
    assign temp_value = temp_valid ? TV : cnt_r;
    assign trig_in = trig_r;
    assign head_present = head_on;
    assign head_id_valid = head_on;
    assign head_id = head_on ? HC : ~HC;
endmodule // srmc_partner
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "srmc_defines.svh"
module testbench;
    localparam int TW = 400;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b0, hd = 1'b0, ign = 1'b0, rd_d = 1'b0;
    logic [3:0] reg_addr = 4'h0, trig_in;
    logic [1:0] psel = 2'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h53f, wc = 32'h0, d, o;
    logic temp_valid, head_present, head_id_valid, led_out, store_req;
    logic [15:0] temp_value, head_id, led_level, ll = 16'h0;
    srmc_pkg::srmc_cfg_type store_cfg;
    int n_mismatch = 0, total_checks = 0;
    logic [31:0] rq[$], wq[$];
    srmc_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in), .temp_valid(temp_valid),
        .temp_value(temp_value), .head_present(head_present), .head_id_valid(head_id_valid), .head_id(head_id),
        .led_out(led_out), .led_level(led_level), .store_req(store_req), .store_cfg(store_cfg));
    srmc_partner #(.TW(TW)) partner (.clk(clk), .rst(rst), .pin_lvl(pin), .pin_sel(psel), .head_on(hd),
        .trig_in(trig_in), .temp_valid(temp_valid), .temp_value(temp_value), .head_present(head_present),
        .head_id_valid(head_id_valid), .head_id(head_id));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] e, input logic [31:0] a);
        total_checks++;
        if (e !== a) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] a);
        cmp(e, a);
    endtask
    task automatic chk_pw(input logic [31:0] e, input logic [31:0] a);
        cmp(e, a);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, v, 2'b10};
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
        @(posedge clk);
    endtask
    task nop();
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge clk);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task cfg(input logic [2:0] m, input logic [31:0] dl, on, off, input logic [15:0] lv, input logic [2:0] c);
        wr(`SRMC_REG_CTRL, {29'h0, m});
        wr(`SRMC_REG_DELAY, dl);
        wr(`SRMC_REG_ON, on);
        wr(`SRMC_REG_OFF, off);
        wr(`SRMC_REG_LEVEL, {16'h0, lv});
        wr(`SRMC_REG_CMD, {29'h0, c});
        nop();
    endtask
    task pulse(input int n);
        pin <= 1'b1;
        psel <= 2'(xs());
        wt(n);
        pin <= 1'b0;
    endtask
    task test_done();
        if (wq.size() != 0 || rq.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always #50 clk = ~clk;
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) if (rd_d) chk_rd(rq.pop_front(), reg_rdata);
    // Every pulse end while ign is low takes a note of level and width; a pulse nobody expected meets an empty queue.
    // Outputs are looked at on the falling edge, where they have settled.
    always @(negedge clk) begin
        if (led_out === 1'b1 && !ign) begin
            wc <= wc + 32'h1;
            ll <= led_level;
        end else if (wc != 32'h0) begin
            chk_pw((wq.size() != 0) ? wq.pop_front() : 32'h0, {ll, wc[15:0]});
            wc <= 32'h0;
        end
    end
    initial begin
        wt(5);
        rst <= 1'b0;
        rd(`SRMC_REG_TEMP, 32'h0);
        rd(`SRMC_REG_HEAD, 32'h0);
        rd(4'he, 32'h0);
        cfg(3'h0, 32'h1, 32'h3, 32'h3, 16'h0100, 3'h1);
        pulse(4);
        wt(30);
        $display("test off done");
        repeat (3) begin
            d = 32'h1 + xs() % 8;
            o = 32'h4 + xs() % 8;
            cfg(3'h1, d, o, 32'h14, 16'h8000, 3'h1);
            wq.push_back({16'h8000, o[15:0]});
            pulse(2);
            wt(1);
            pulse(2);
            wt(d + o + 20);
        end
        cfg(3'h2, 32'h2, 32'h5, 32'h5, 16'h8000, 3'h1);
        pulse(3);
        wt(20);
        wq.push_back(32'h8000_0005);
        wr(`SRMC_REG_CMD, 32'h4);
        nop();
        wt(20);
        $display("test triggered done");
        ign <= 1'b1;
        cfg(3'h3, 32'h7, 32'h7, 32'h7, 16'hffff, 3'h2);
        rd(`SRMC_REG_ACT_CTRL, 32'h3);
        rd(`SRMC_REG_ACT_LEVEL, 32'hffff);
        cfg(3'h0, 32'h7, 32'h7, 32'h7, 16'h0, 3'h1);
        wt(5);
        ign <= 1'b0;
        o = 32'h3 + xs() % 8;
        cfg(3'h4, 32'h9, 32'h9, 32'h9, 16'h8000, 3'h1);
        wq.push_back({16'h3fff, o[15:0]});
        pulse(o);
        wt(10);
        $display("test dc done");
        repeat (3) wq.push_back(32'h8000_0003);
        cfg(3'h5, 32'h2, 32'h3, 32'h14, 16'h8000, 3'h1);
        pulse(2);
        wr(`SRMC_REG_CMD, 32'h4);
        nop();
        for (int i = 0; i < 300 && wq.size() != 0; i++) @(posedge clk);
        cfg(3'h1, 32'h2, 32'h3, 32'h3, 16'h0, 3'h1);
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        rd(`SRMC_REG_ACT_CTRL, 32'h0);
        nop();
        hd <= 1'b1;
        wt(TW + 5);
        rd(`SRMC_REG_TEMP, 32'h24);
        rd(`SRMC_REG_HEAD, 32'h5a17);
        nop();
        wt(3);
        $display("test status done");
        test_done();
    end
    initial begin
        wt(5000);
        n_mismatch++;
        test_done();
    end
endmodule // testbench
bind srmc_top srmc_props #(.TRIG_N(TRIG_N)) u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .led_out(led_out), .led_level(led_level), .store_req(store_req), .store_cfg(store_cfg));
`default_nettype wire
